// *** logic/spi_ctl.sv ***
// Serial peripheral controller, master and slave, with AHB-Lite registers.
// Assumes pins synchronous to hclk; the bus master issues single words.
// How it works
// - Master drives eight serial clocks per byte
// - Master drives MOSI, selected slave drives MISO
// - Master select bit set means master mode
// - Data write starts master transfer only
// - Write loads shifter; read returns holding byte
// - Most significant bit goes first
// - Master shifts MISO in while MOSI out
// - Each finished byte sets the done flag
// - Master: disable bit frees select pin
// - Slave when master bit clear, byte loaded
// - Slave shifts on master clock, drives MISO
// - Slave disable bit ignored when phase zero
// - Rate field picks divider 2..128; code 7 also gives 2
// - Polarity sets idle level, phase picks edges
// - Disabled interface holds clock high
// - Master samples MISO, slave samples MOSI
// - Mode fault sets flag, clears enable, master
// - Write during transfer flags collision, dropped
// - Done and fault form one request
`timescale 1ns/10ps
`default_nettype none
module spi_ctl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_in_n,
  output logic ss_free,
  output logic irq
);
  import spi_ctl_pkg::*;

  ctrl_s ctrl_q, ctrl_d;
  logic [7:0] shift_q, shift_d, hold_q, hold_d;
  logic done_q, done_d, write_collision_flag_q, write_collision_flag_d, mode_fault_flag_q, mode_fault_flag_d;
  logic stat_rd_q, stat_rd_d;
  logic loaded_q, loaded_d;
  logic [2:0] cnt_q, cnt_d;
  shift_state_e st_q, st_d;
  logic sck_q, sck_d, mosi_q, mosi_d, miso_q, miso_d, miso_oe_q, miso_oe_d;
  logic sck_oe_q, sck_oe_d, mosi_oe_q, mosi_oe_d;
  logic ss_free_q, ss_free_d, irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic ap_wr_q, ap_rd_q;
  logic [7:0] ap_addr_q;
  logic ap_wr_d, ap_rd_d;
  logic [7:0] ap_addr_d;
  logic tick, sck_rise, sck_fall, ss_rise, ss_fall;
  logic busy, is_master, ss_used, selected, lead_edge, trail_edge;
  logic data_wr, data_rd, ctrl_wr, stat_rd, xfer_end, fault;
  logic [7:0] wbyte;

  assign busy = (st_q != st_idle);
  assign is_master = ctrl_q.master;
  // Slave select pin honoured unless freed; freeing needs phase one in slave
  assign ss_used = is_master ? ~ctrl_q.select_pin_disable_bit
                 : ~(ctrl_q.select_pin_disable_bit & ctrl_q.phase);
  assign selected = ~ss_used | ~ss_in_n;

  spi_rate_div u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(is_master && busy),
    .rate({ctrl_q.rate2, ctrl_q.rate1, ctrl_q.rate0}),
    .tick(tick)
  );
  spi_edge_det u_sck_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(sck_in),
    .init(1'b0),
    .rise(sck_rise),
    .fall(sck_fall)
  );
  spi_edge_det u_ss_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(ss_in_n),
    .init(1'b0),
    .rise(ss_rise),
    .fall(ss_fall)
  );

  // Leading edge is away from idle level, trailing edge returns to it
  always_comb begin
    if (ctrl_q.idle_level) begin
      lead_edge = sck_fall;
      trail_edge = sck_rise;
    end else begin
      lead_edge = sck_rise;
      trail_edge = sck_fall;
    end
  end

  // Bus address phase capture
  always_comb begin
    ap_wr_d = 1'b0;
    ap_rd_d = 1'b0;
    ap_addr_d = ap_addr_q;
    if (hsel && hready && htrans[1]) begin
      ap_wr_d = hwrite;
      ap_rd_d = ~hwrite;
      ap_addr_d = haddr[7:0];
    end
  end
  assign wbyte = hwdata[7:0];
  assign data_wr = ap_wr_q && (ap_addr_q == data_off);
  assign ctrl_wr = ap_wr_q && (ap_addr_q == ctrl_off);
  assign data_rd = ap_rd_d && (ap_addr_d == data_off);
  assign stat_rd = ap_rd_d && (ap_addr_d == stat_off);
  assign fault = is_master && ctrl_q.enable && ss_used && ~ss_in_n;

  // Read data registered during the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (stat_rd) begin
      rdata_d[done_pos] = done_q;
      rdata_d[write_collision_flag_pos] = write_collision_flag_q;
      rdata_d[mode_fault_flag_pos] = mode_fault_flag_q;
    end else if (ap_rd_d && ap_addr_d == ctrl_off) begin
      rdata_d[7:0] = ctrl_q;
    end else if (data_rd) begin
      rdata_d[7:0] = hold_q;
    end else if (ap_rd_d && ap_addr_d == pin_off) begin
      rdata_d[0] = ss_in_n;
    end
  end

  // Shifter and control
  always_comb begin
    ctrl_d = ctrl_q;
    shift_d = shift_q;
    hold_d = hold_q;
    cnt_d = cnt_q;
    st_d = st_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    miso_d = miso_q;
    loaded_d = loaded_q;
    done_d = done_q;
    write_collision_flag_d = write_collision_flag_q;
    mode_fault_flag_d = mode_fault_flag_q;
    stat_rd_d = stat_rd_q | stat_rd;
    xfer_end = 1'b0;
    if (ctrl_wr) begin
      ctrl_d = ctrl_s'(wbyte);
      if (stat_rd_q) begin
        mode_fault_flag_d = 1'b0;
      end
    end
    if (data_wr) begin
      if (busy) begin
        write_collision_flag_d = 1'b1;
      end else begin
        shift_d = wbyte;
        loaded_d = 1'b1;
        if (stat_rd_q) begin
          write_collision_flag_d = 1'b0;
        end
        if (is_master && ctrl_q.enable) begin
          st_d = st_lead;
          cnt_d = bit_count_zero;
          sck_d = ctrl_q.idle_level;
          // Phase zero: first bit out before any edge
          mosi_d = wbyte[7];
        end
      end
    end
    if (is_master) begin
      if (busy && tick) begin
        sck_d = ~sck_q;
        if (st_q == st_lead) begin
          st_d = st_trail;
          if (ctrl_q.phase) begin
            mosi_d = shift_q[7];
          end else begin
            shift_d = {shift_q[6:0], miso_in};
          end
        end else begin
          st_d = st_lead;
          if (ctrl_q.phase) begin
            shift_d = {shift_q[6:0], miso_in};
          end else begin
            mosi_d = shift_q[7];
          end
          if (cnt_q == bit_count_last) begin
            st_d = st_idle;
            xfer_end = 1'b1;
          end
          cnt_d = 3'(cnt_q + 3'h1);
        end
      end
    end else if (ctrl_q.enable && loaded_q && selected) begin
      // Slave follows the master clock
      if (ss_fall && !ctrl_q.phase) begin
        miso_d = shift_q[7];
      end
      if (lead_edge) begin
        st_d = st_trail;
        if (ctrl_q.phase) begin
          miso_d = shift_q[7];
        end else begin
          shift_d = {shift_q[6:0], mosi_in};
        end
      end else if (trail_edge) begin
        if (ctrl_q.phase) begin
          shift_d = {shift_q[6:0], mosi_in};
        end else begin
          miso_d = shift_q[7];
        end
        cnt_d = 3'(cnt_q + 3'h1);
        if (cnt_q == bit_count_last) begin
          st_d = st_idle;
          xfer_end = 1'b1;
        end
      end
    end
    if (!is_master && ss_used && ss_rise) begin
      // Deselect aborts a partial byte
      cnt_d = bit_count_zero;
      st_d = st_idle;
    end
    if (xfer_end) begin
      hold_d = shift_d;
      if (!is_master) begin
        loaded_d = 1'b0;
      end
    end
    // Done cleared by status read then data access; new end wins
    if (stat_rd_q && (data_rd || data_wr)) begin
      done_d = 1'b0;
    end
    // A data write uses up the status read; a read keeps it for collision
    if (stat_rd_q && data_wr) begin
      stat_rd_d = stat_rd;
    end
    if (xfer_end) begin
      done_d = 1'b1;
    end
    if (fault) begin
      mode_fault_flag_d = 1'b1;
      ctrl_d.enable = 1'b0;
      ctrl_d.master = 1'b0;
      st_d = st_idle;
    end
    if (!ctrl_d.enable) begin
      st_d = st_idle;
    end
    if (!ctrl_q.enable) begin
      sck_d = 1'b1;
    end else if (!is_master || st_d == st_idle) begin
      sck_d = ctrl_q.idle_level;
    end
  end

  // Pin drive and interrupt
  always_comb begin
    sck_oe_d = ctrl_q.master;
    mosi_oe_d = ctrl_q.master && ctrl_q.enable;
    miso_oe_d = ~ctrl_q.master && ctrl_q.enable && selected;
    ss_free_d = ctrl_q.select_pin_disable_bit && (ctrl_q.master || ctrl_q.phase);
    irq_d = done_d | mode_fault_flag_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ctrl_s'(ctrl_reset);
      shift_q <= byte_reset;
      hold_q <= byte_reset;
      cnt_q <= bit_count_zero;
      st_q <= st_idle;
      sck_q <= 1'b1;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      ss_free_q <= 1'b0;
      irq_q <= 1'b0;
      loaded_q <= 1'b0;
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      stat_rd_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      shift_q <= shift_d;
      hold_q <= hold_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      miso_q <= miso_d;
      sck_oe_q <= sck_oe_d;
      mosi_oe_q <= mosi_oe_d;
      miso_oe_q <= miso_oe_d;
      ss_free_q <= ss_free_d;
      irq_q <= irq_d;
      loaded_q <= loaded_d;
      done_q <= done_d;
      write_collision_flag_q <= write_collision_flag_d;
      mode_fault_flag_q <= mode_fault_flag_d;
      stat_rd_q <= stat_rd_d;
      rdata_q <= rdata_d;
      ap_wr_q <= ap_wr_d;
      ap_rd_q <= ap_rd_d;
      ap_addr_q <= ap_addr_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sck_out = sck_q;
  assign sck_oe = sck_oe_q;
  assign mosi_out = mosi_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_out = miso_q;
  assign miso_oe = miso_oe_q;
  assign ss_free = ss_free_q;
  assign irq = irq_q;
endmodule // spi_ctl
`default_nettype wire

// *** logic/spi_ctl_pkg.sv ***
// Package for the serial peripheral controller: register map, fields,
// reset values and shared types. Assumes an AHB-Lite slave with 32-bit data.
`default_nettype none
package spi_ctl_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] stat_off = 8'h04;
  localparam logic [7:0] data_off = 8'h08;
  localparam logic [7:0] pin_off = 8'h0C;

  // Control field positions
  localparam int rate_b0_pos = 0;
  localparam int rate_b1_pos = 1;
  localparam int phase_pos = 2;
  localparam int idle_pos = 3;
  localparam int master_pos = 4;
  localparam int select_pin_disable_bit_pos = 5;
  localparam int enable_pos = 6;
  localparam int rate_b2_pos = 7;

  // Status field positions
  localparam int done_pos = 7;
  localparam int write_collision_flag_pos = 6;
  localparam int mode_fault_flag_pos = 4;

  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [2:0] bit_count_last = 3'h7;
  localparam logic [2:0] bit_count_zero = 3'h0;
  localparam logic [2:0] rate_div1 = 3'h7;
  localparam logic [6:0] div_zero = 7'h00;
  localparam logic [6:0] div_one = 7'h01;

  localparam logic [1:0] htrans_nonseq = 2'b10;
  localparam logic [2:0] hsize_word = 3'b010;

  // Control fields as one carrier
  typedef struct packed {
    logic rate2;
    logic enable;
    logic select_pin_disable_bit;
    logic master;
    logic idle_level;
    logic phase;
    logic rate1;
    logic rate0;
  } ctrl_s;

  // Serial pins toward the shifter
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_s;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_lead = 2'b01,
    st_trail = 2'b11
  } shift_state_e;
endpackage
`default_nettype wire

// *** logic/spi_edge_det.sv ***
// Edge detector on a synchronous pin level; registered copy of the level.
// Assumes inputs are already synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module spi_edge_det (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  input wire logic init,
  output logic rise,
  output logic fall
);
  logic prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= din;
    end
  end
  assign rise = din & ~prev_q & ~init;
  assign fall = ~din & prev_q & ~init;
endmodule // spi_edge_det

// *** logic/spi_rate_div.sv ***
// Bit rate generator: one-cycle tick at the half-period of the serial clock.
// Assumes the peripheral clock is hclk.
`timescale 1ns/10ps
`default_nettype none
module spi_rate_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [2:0] rate,
  output logic tick
);
  import spi_ctl_pkg::*;
  logic [6:0] cnt_q, cnt_d;
  logic [6:0] half;
  always_comb begin
    // Divider 2,4..128 gives half periods 1..64 cycles; code 7 also gives half period 1
    if (rate == rate_div1) begin
      half = div_one;
    end else begin
      half = 7'(div_one << rate);
    end
    cnt_d = cnt_q;
    tick = 1'b0;
    if (!run) begin
      cnt_d = div_zero;
    end else if (cnt_q + div_one >= half) begin
      cnt_d = div_zero;
      tick = 1'b1;
    end else begin
      cnt_d = 7'(cnt_q + div_one);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= div_zero;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // spi_rate_div

// *** sim/spi_ctl_checker.sv ***
// Checker for the serial controller: bus answer and pin drive relations.
// Assumes it is bound to spi_ctl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module spi_ctl_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_in_n,
  input wire logic ss_free,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Recent register writes; their effects land a few cycles later
  logic [3:0] wr_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_q <= 4'h0;
    else wr_q <= {wr_q[2:0], hsel && htrans[1] && hwrite};

  chk_ready_const: assert property (hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp)
    else $error("error response given");
  chk_mosi_master: assert property (mosi_oe |-> sck_oe)
    else $error("MOSI driven outside master mode");
  chk_miso_slave: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("MISO driven outside slave mode");
  chk_miso_float: assert property (
    (!ss_free && ss_in_n) [*3] |-> !miso_oe)
    else $error("MISO driven while deselected");
  chk_fault_stop: assert property (
    mosi_oe && !ss_free && !ss_in_n && wr_q[1:0] == 2'b00 |-> ##[1:4]
    (!sck_oe && !mosi_oe && irq))
    else $error("mode fault not taken");
  chk_freed_hold: assert property (
    (mosi_oe && ss_free && !ss_in_n && wr_q == 4'h0) [*2] |=> mosi_oe)
    else $error("freed select pin caused a fault");
  chk_fault_hold: assert property (
    !sck_oe && irq && wr_q == 4'h0 && !(hsel && htrans[1] && hwrite)
    |=> !sck_oe)
    else $error("master mode back without a write");
  cover property ($rose(irq) && sck_oe);
  cover property ($fell(sck_oe) && irq);
  cover property ($rose(miso_oe));
endmodule // spi_ctl_checker
bind spi_ctl spi_ctl_checker u_spi_ctl_checker (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hreadyout, .hresp, .sck_oe, .mosi_oe, .miso_oe,
  .ss_in_n, .ss_free, .irq);
`default_nettype wire

// *** sim/spi_slave_model.sv ***
// External serial slave: shifts a byte out on MISO and collects MOSI.
// Assumes select, mode and the byte to send are set by the bench.
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic clock_idle_level_bit,
  input wire logic clock_edge_phase_bit,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx,
  output int edges
);
  logic [7:0] sh;
  logic lead;
  initial miso = 1'b0;
  always @(negedge ss_n) begin
    sh = tx;
    edges = 0;
    if (!clock_edge_phase_bit) miso = sh[7];
  end
  // Released line: show the inverse so stale data never matches
  always @(posedge ss_n) miso = ~miso;
  always @(sck) if (!ss_n) begin
    edges++;
    lead = (sck != clock_idle_level_bit);
    if (lead != clock_edge_phase_bit) rx = {rx[6:0], mosi};
    else if (clock_edge_phase_bit) begin
      miso = sh[7];
      sh = sh << 1;
    end else begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule // spi_slave_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Testbench: registers over AHB-Lite, master runs, fault and slave run.
// Assumes the controller package and the external slave model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("BAD %0t got %0h want %0h", $time, a, b); \
  end \
end
module tb_top;
  import spi_ctl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, sel_n, ss_in_n;
  logic hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, ss_free, irq, mdl_miso, sck_drv, mosi_drv;
  logic clock_idle_level_bit, clock_edge_phase_bit;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] mdl_tx, mdl_rx, got;
  ctrl_s cs;
  int mdl_edges, num_errors, tests_run, n, half;
  wire logic sck_w = sck_oe ? sck_out : sck_drv;
  wire logic mosi_w = mosi_oe ? mosi_out : mosi_drv;
  wire logic miso_w = miso_oe ? miso_out : mdl_miso;
  assign hready = hreadyout;
  spi_ctl u_spi_ctl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out,
    .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_in_n,
    .ss_free, .irq);
  spi_slave_model u_spi_slave_model (.sck(sck_w), .mosi(mosi_w),
    .ss_n(sel_n), .clock_idle_level_bit, .clock_edge_phase_bit, .tx(mdl_tx), .miso(mdl_miso),
    .rx(mdl_rx), .edges(mdl_edges));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] r);
    htrans <= htrans_nonseq;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    `CHK(r, e);
  endtask
  task automatic wait_change(output int c);
    logic s;
    s = sck_w;
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (sck_w === s && c < 300);
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    `CHK(irq, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] d,
      input logic [7:0] s, input int h, input logic col);
    clock_idle_level_bit = c[idle_pos];
    clock_edge_phase_bit = c[phase_pos];
    mdl_tx = s;
    wr(ctrl_off, c);
    repeat (2) @(posedge hclk);
    `CHK(sck_w, clock_idle_level_bit);
    `CHK(sck_oe, 1'b1);
    `CHK(ss_free, 1'b1);
    sel_n <= 1'b0;
    @(posedge hclk);
    wr(data_off, d);
    if (col) wr(data_off, ~d);
    wait_change(n);
    wait_change(half);
    `CHK(half, h);
    wait_irq();
    `CHK(mdl_edges, 16);
    `CHK(mdl_rx, d);
    sel_n <= 1'b1;
    rd(stat_off, (8'h01 << done_pos) | ({7'h00, col} << write_collision_flag_pos));
    rd(data_off, s);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0);
  endtask
  task automatic finish_test();
    $display("errors %0d in %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Longest run is eight transfers up to 1024 cycles each; allow plenty
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    {hresetn, hwrite, sck_drv, mosi_drv, clock_idle_level_bit, clock_edge_phase_bit} = 6'h00;
    {hsel, sel_n, ss_in_n} = 3'h7;
    htrans = 2'b00;
    hsize = hsize_word;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    mdl_tx = 8'h00;
    num_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge hclk);
    `CHK(sck_out, 1'b1);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ctrl_off, ctrl_reset);
    rd(stat_off, byte_reset);
    rd(pin_off, 8'h01);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ss_in_n <= 1'b0;
      cs = '{rate2: i[2], enable: 1'b1, select_pin_disable_bit: 1'b1, master: 1'b1,
        idle_level: i[0], phase: i[1], rate1: i[1], rate0: i[0]};
      xfer(cs, 8'hA5 ^ 8'(i), 8'h3C + 8'(i), (i == 7) ? 1 : (1 << i),
        i == 1);
    end
    ss_in_n <= 1'b1;
    wr(ctrl_off, 8'h50);
    ss_in_n <= 1'b0;
    wait_irq();
    rd(ctrl_off, 8'h00);
    rd(stat_off, 8'h01 << mode_fault_flag_pos);
    ss_in_n <= 1'b1;
    // Slave runs in both clock phases
    for (int p = 0; p < 2; p++) begin
      wr(ctrl_off, (8'h01 << enable_pos) | (8'(p) << phase_pos));
      wr(data_off, 8'hC3);
      `CHK(sck_oe, 1'b0);
      ss_in_n <= 1'b0;
      for (int b = 7; b >= 0; b--) begin
        sck_drv <= 1'b1;
        mosi_drv <= b == 6 || b == 4 || b == 3 || b == 1;
        repeat (4) @(posedge hclk);
        got[b] = miso_w;
        sck_drv <= 1'b0;
        repeat (4) @(posedge hclk);
      end
      `CHK(got, 8'hC3);
      ss_in_n <= 1'b1;
      wait_irq();
      rd(stat_off, 8'h01 << done_pos);
      rd(data_off, 8'h5A);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
